//--- decoder_pkg.sv
package decoder_pkg;

    // ************************************************************
    // Operations and instruction forms
    // ************************************************************
    typedef enum logic [3:0] {
        OP_UNSUPPORTED,
        LOAD_EFFECTIVE_ADDRESS_OP,
        LOAD_POINTER_DATA_SEG_OP,
        LOAD_POINTER_EXTRA_SEG_OP,
        FLAGS_TO_ACC_HIGH_OP,
        ACC_HIGH_TO_FLAGS_OP,
        ADD_OP,
        ADD_CARRY_OP,
        SUB_OP
    } op_type;

    typedef enum logic [1:0] {
        FORM_SINGLE,
        FORM_MODRM,
        FORM_RM_IMM,
        FORM_ACC_IMM
    } form_type;

    typedef enum logic [1:0] {
        ST_OPCODE,
        ST_MODRM,
        ST_IMM_LO,
        ST_IMM_HI
    } state_type;

    // ************************************************************
    // Opcode encodings
    // ************************************************************
    localparam logic [7:0] OPC_LOAD_ADDR          = 8'h8d;
    localparam logic [7:0] OPC_LOAD_PTR_DATA      = 8'hc5;
    localparam logic [7:0] OPC_LOAD_PTR_EXTRA     = 8'hc4;
    localparam logic [7:0] OPC_FLAGS_TO_ACC_HIGH  = 8'h9f;
    localparam logic [7:0] OPC_ACC_HIGH_TO_FLAGS  = 8'h9e;
    localparam logic [5:0] PAT_ADD_RM       = 6'h00;
    localparam logic [5:0] PAT_ADC_RM       = 6'h04;
    localparam logic [5:0] PAT_SUB_RM       = 6'h0a;
    localparam logic [5:0] PAT_IMM_GROUP    = 6'h20;
    localparam logic [6:0] PAT_ADD_ACC      = 7'h02;
    localparam logic [6:0] PAT_ADC_ACC      = 7'h0a;
    localparam logic [2:0] REG_SEL_ADD      = 3'h0;
    localparam logic [2:0] REG_SEL_ADC      = 3'h2;
    localparam logic [1:0] MOD_REGISTER     = 2'h3;
    localparam logic [1:0] SW_WORD_IMM      = 2'h1;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_W    = 0;
    localparam int BIT_D    = 1;
    localparam int BIT_S    = 1;
    localparam int MOD_HI   = 7;
    localparam int MOD_LO   = 6;
    localparam int REG_HI   = 5;
    localparam int REG_LO   = 3;
    localparam int RM_HI    = 2;
    localparam int SIGN_BIT = 7;

    // ************************************************************
    // Execution clock counts
    // ************************************************************
    localparam int COUNT_W = 5;
    localparam logic [COUNT_W-1:0] CLK_LOAD_ADDR   = 5'h03;
    localparam logic [COUNT_W-1:0] CLK_PTR_REAL    = 5'h07;
    localparam logic [COUNT_W-1:0] CLK_PTR_PROT    = 5'h15;
    localparam logic [COUNT_W-1:0] CLK_FLAGS_MOVE  = 5'h02;
    localparam logic [COUNT_W-1:0] CLK_ALU_REG     = 5'h02;
    localparam logic [COUNT_W-1:0] CLK_ALU_MEM     = 5'h07;
    localparam logic [COUNT_W-1:0] CLK_IMM_REG     = 5'h03;
    localparam logic [COUNT_W-1:0] CLK_IMM_MEM     = 5'h07;
    localparam logic [COUNT_W-1:0] CLK_ACC_IMM     = 5'h03;
    localparam logic [COUNT_W-1:0] CLK_NONE        = 5'h00;

endpackage : decoder_pkg

//--- opcode_classifier.sv
`timescale 1ns/1ps
`default_nettype none
module opcode_classifier (
    // Opcode byte
    input  wire logic [7:0]          opcodeByte,
    // Classification
    output var decoder_pkg::op_type   opKind,
    output var decoder_pkg::form_type formKind
);

    always_comb begin
        opKind   = decoder_pkg::OP_UNSUPPORTED;
        formKind = decoder_pkg::FORM_SINGLE;
        if (opcodeByte == decoder_pkg::OPC_LOAD_ADDR) begin
            opKind   = decoder_pkg::LOAD_EFFECTIVE_ADDRESS_OP;
            formKind = decoder_pkg::FORM_MODRM;
        end else if (opcodeByte == decoder_pkg::OPC_LOAD_PTR_DATA) begin
            opKind   = decoder_pkg::LOAD_POINTER_DATA_SEG_OP;
            formKind = decoder_pkg::FORM_MODRM;
        end else if (opcodeByte == decoder_pkg::OPC_LOAD_PTR_EXTRA) begin
            opKind   = decoder_pkg::LOAD_POINTER_EXTRA_SEG_OP;
            formKind = decoder_pkg::FORM_MODRM;
        end else if (opcodeByte == decoder_pkg::OPC_FLAGS_TO_ACC_HIGH) begin
            opKind = decoder_pkg::FLAGS_TO_ACC_HIGH_OP;
        end else if (opcodeByte == decoder_pkg::OPC_ACC_HIGH_TO_FLAGS) begin
            opKind = decoder_pkg::ACC_HIGH_TO_FLAGS_OP;
        end else if (opcodeByte[7:2] == decoder_pkg::PAT_ADD_RM) begin
            opKind   = decoder_pkg::ADD_OP;
            formKind = decoder_pkg::FORM_MODRM;
        end else if (opcodeByte[7:2] == decoder_pkg::PAT_ADC_RM) begin
            opKind   = decoder_pkg::ADD_CARRY_OP;
            formKind = decoder_pkg::FORM_MODRM;
        end else if (opcodeByte[7:2] == decoder_pkg::PAT_SUB_RM) begin
            opKind   = decoder_pkg::SUB_OP;
            formKind = decoder_pkg::FORM_MODRM;
        end else if (opcodeByte[7:2] == decoder_pkg::PAT_IMM_GROUP) begin
            // The operation is fixed later by the reg field of the ModR/M byte.
            formKind = decoder_pkg::FORM_RM_IMM;
        end else if (opcodeByte[7:1] == decoder_pkg::PAT_ADD_ACC) begin
            opKind   = decoder_pkg::ADD_OP;
            formKind = decoder_pkg::FORM_ACC_IMM;
        end else if (opcodeByte[7:1] == decoder_pkg::PAT_ADC_ACC) begin
            opKind   = decoder_pkg::ADD_CARRY_OP;
            formKind = decoder_pkg::FORM_ACC_IMM;
        end
    end

endmodule : opcode_classifier
`default_nettype wire

//--- load_flag_add_sub_opcode_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module load_flag_add_sub_opcode_decoder #(
    parameter int COUNT_W = decoder_pkg::COUNT_W
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // Byte stream from the prefetch queue
    input  wire logic                   byteValid,
    input  wire logic [7:0]             byteData,
    // Operating mode, high in protected mode
    input  wire logic                   protMode,
    // Decoded instruction
    output logic                        decValid,
    output var decoder_pkg::op_type     decOp,
    output logic                        decUnsupported,
    output logic                        decIllegal,
    output logic                        wordWidth,
    output logic                        regIsDest,
    output logic                        memOperand,
    output logic [1:0]                  modField,
    output logic [2:0]                  regField,
    output logic [2:0]                  rmField,
    output logic [15:0]                 immValue,
    output logic [1:0]                  immCount,
    output logic [COUNT_W-1:0]          clockCount
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (COUNT_W < decoder_pkg::COUNT_W) begin : g_bad_width
        $error("COUNT_W too narrow for the largest clock count.");
    end

    // ************************************************************
    // Clock count lookup
    // ************************************************************
    function automatic logic [decoder_pkg::COUNT_W-1:0] count_of(
        input decoder_pkg::op_type   op,
        input decoder_pkg::form_type form,
        input logic                  isMem,
        input logic                  prot
    );
        logic [decoder_pkg::COUNT_W-1:0] cnt;
        cnt = decoder_pkg::CLK_NONE;
        unique case (op)
            decoder_pkg::LOAD_EFFECTIVE_ADDRESS_OP: cnt = decoder_pkg::CLK_LOAD_ADDR;
            decoder_pkg::LOAD_POINTER_DATA_SEG_OP,
            decoder_pkg::LOAD_POINTER_EXTRA_SEG_OP: begin
                cnt = prot ? decoder_pkg::CLK_PTR_PROT : decoder_pkg::CLK_PTR_REAL;
            end
            decoder_pkg::FLAGS_TO_ACC_HIGH_OP,
            decoder_pkg::ACC_HIGH_TO_FLAGS_OP: cnt = decoder_pkg::CLK_FLAGS_MOVE;
            decoder_pkg::ADD_OP,
            decoder_pkg::ADD_CARRY_OP,
            decoder_pkg::SUB_OP: begin
                if (form == decoder_pkg::FORM_ACC_IMM) begin
                    cnt = decoder_pkg::CLK_ACC_IMM;
                end else if (form == decoder_pkg::FORM_RM_IMM) begin
                    cnt = isMem ? decoder_pkg::CLK_IMM_MEM : decoder_pkg::CLK_IMM_REG;
                end else begin
                    cnt = isMem ? decoder_pkg::CLK_ALU_MEM : decoder_pkg::CLK_ALU_REG;
                end
            end
            decoder_pkg::OP_UNSUPPORTED: cnt = decoder_pkg::CLK_NONE;
        endcase
        return cnt;
    endfunction : count_of

    // ************************************************************
    // Captured bytes and sequencing
    // ************************************************************
    decoder_pkg::state_type stateReg;
    decoder_pkg::state_type stateNext;
    logic [7:0]             opcodeReg;
    logic [7:0]             modrmReg;
    logic [7:0]             immLoReg;
    logic [7:0]             effOpcode;
    logic [7:0]             effModrm;
    logic [7:0]             effImmLo;
    decoder_pkg::op_type    classOp;
    decoder_pkg::form_type  classForm;
    decoder_pkg::op_type    finalOp;
    logic                   twoImm;
    logic                   isMem;
    logic                   done;

    assign effOpcode = (stateReg == decoder_pkg::ST_OPCODE) ? byteData : opcodeReg;
    assign effModrm  = (stateReg == decoder_pkg::ST_MODRM)  ? byteData : modrmReg;
    assign effImmLo  = (stateReg == decoder_pkg::ST_IMM_LO) ? byteData : immLoReg;
    assign isMem     = effModrm[decoder_pkg::MOD_HI:decoder_pkg::MOD_LO] != decoder_pkg::MOD_REGISTER;

    opcode_classifier u_classifier (
        .opcodeByte (effOpcode),
        .opKind     (classOp),
        .formKind   (classForm)
    );

    always_comb begin
        twoImm = effOpcode[decoder_pkg::BIT_W];
        if (classForm == decoder_pkg::FORM_RM_IMM) begin
            twoImm = effOpcode[1:0] == decoder_pkg::SW_WORD_IMM;
        end
    end

    always_comb begin
        finalOp = classOp;
        if (classForm == decoder_pkg::FORM_RM_IMM) begin
            unique case (effModrm[decoder_pkg::REG_HI:decoder_pkg::REG_LO])
                decoder_pkg::REG_SEL_ADD: finalOp = decoder_pkg::ADD_OP;
                decoder_pkg::REG_SEL_ADC: finalOp = decoder_pkg::ADD_CARRY_OP;
                default:                  finalOp = decoder_pkg::OP_UNSUPPORTED;
            endcase
        end
    end

    always_comb begin
        stateNext = stateReg;
        done      = 1'b0;
        if (byteValid) begin
            unique case (stateReg)
                decoder_pkg::ST_OPCODE: begin
                    unique case (classForm)
                        decoder_pkg::FORM_SINGLE:  done = 1'b1;
                        decoder_pkg::FORM_ACC_IMM: stateNext = decoder_pkg::ST_IMM_LO;
                        decoder_pkg::FORM_MODRM,
                        decoder_pkg::FORM_RM_IMM:  stateNext = decoder_pkg::ST_MODRM;
                    endcase
                end
                decoder_pkg::ST_MODRM: begin
                    if (classForm == decoder_pkg::FORM_RM_IMM) begin
                        stateNext = decoder_pkg::ST_IMM_LO;
                    end else begin
                        stateNext = decoder_pkg::ST_OPCODE;
                        done      = 1'b1;
                    end
                end
                decoder_pkg::ST_IMM_LO: begin
                    if (twoImm) begin
                        stateNext = decoder_pkg::ST_IMM_HI;
                    end else begin
                        stateNext = decoder_pkg::ST_OPCODE;
                        done      = 1'b1;
                    end
                end
                decoder_pkg::ST_IMM_HI: begin
                    stateNext = decoder_pkg::ST_OPCODE;
                    done      = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stateReg <= decoder_pkg::ST_OPCODE;
        end else begin
            stateReg <= stateNext;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            opcodeReg <= 8'h00;
            modrmReg  <= 8'h00;
            immLoReg  <= 8'h00;
        end else if (byteValid) begin
            opcodeReg <= effOpcode;
            modrmReg  <= effModrm;
            immLoReg  <= effImmLo;
        end
    end

    // ************************************************************
    // Decoded outputs
    // ************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            decValid <= 1'b0;
        end else begin
            decValid <= done;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            decOp          <= decoder_pkg::OP_UNSUPPORTED;
            decUnsupported <= 1'b0;
            decIllegal     <= 1'b0;
            wordWidth      <= 1'b0;
            regIsDest      <= 1'b0;
            memOperand     <= 1'b0;
            modField       <= 2'h0;
            regField       <= 3'h0;
            rmField        <= 3'h0;
            immValue       <= 16'h0000;
            immCount       <= 2'h0;
            clockCount     <= '0;
        end else if (done) begin
            decOp          <= finalOp;
            decUnsupported <= finalOp == decoder_pkg::OP_UNSUPPORTED;
            // Pointer loads need a memory operand.
            decIllegal     <= !isMem && (finalOp == decoder_pkg::LOAD_POINTER_DATA_SEG_OP ||
                              finalOp == decoder_pkg::LOAD_POINTER_EXTRA_SEG_OP);
            modField       <= effModrm[decoder_pkg::MOD_HI:decoder_pkg::MOD_LO];
            regField       <= effModrm[decoder_pkg::REG_HI:decoder_pkg::REG_LO];
            rmField        <= effModrm[decoder_pkg::RM_HI:0];
            memOperand     <= classForm inside {decoder_pkg::FORM_MODRM,
                              decoder_pkg::FORM_RM_IMM} && isMem;
            clockCount     <= COUNT_W'(count_of(finalOp, classForm, isMem, protMode));
            unique case (classForm)
                decoder_pkg::FORM_MODRM: begin
                    if (classOp inside {decoder_pkg::ADD_OP, decoder_pkg::ADD_CARRY_OP,
                                        decoder_pkg::SUB_OP}) begin
                        wordWidth <= effOpcode[decoder_pkg::BIT_W];
                        regIsDest <= effOpcode[decoder_pkg::BIT_D];
                    end else begin
                        wordWidth <= 1'b1;
                        regIsDest <= 1'b1;
                    end
                end
                decoder_pkg::FORM_SINGLE: begin
                    wordWidth <= 1'b0;
                    regIsDest <= 1'b0;
                end
                decoder_pkg::FORM_RM_IMM,
                decoder_pkg::FORM_ACC_IMM: begin
                    wordWidth <= effOpcode[decoder_pkg::BIT_W];
                    regIsDest <= 1'b0;
                end
            endcase
            if (stateReg == decoder_pkg::ST_IMM_HI) begin
                immValue <= {byteData, immLoReg};
                immCount <= 2'h2;
            end else if (stateReg == decoder_pkg::ST_IMM_LO) begin
                // An 8-bit immediate with s set is sign extended to the word.
                immValue <= {{8{classForm == decoder_pkg::FORM_RM_IMM &&
                                effOpcode[decoder_pkg::BIT_S] &&
                                byteData[decoder_pkg::SIGN_BIT]}}, byteData};
                immCount <= 2'h1;
            end else begin
                immValue <= 16'h0000;
                immCount <= 2'h0;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_flag_op_byte;
        stateReg == decoder_pkg::ST_OPCODE && byteValid &&
        byteData[7:1] == 7'h4f;
    endsequence

    sequence s_flag_result;
        decValid && clockCount == COUNT_W'(decoder_pkg::CLK_FLAGS_MOVE) && immCount == 2'h0;
    endsequence

    chk_load_addr_count: assert property (@(posedge clk) disable iff (sys_rst)
        decValid && decOp == decoder_pkg::LOAD_EFFECTIVE_ADDRESS_OP |-> clockCount == 3)
        else $error("Effective address load count is not 3.");
    chk_ptr_data_count: assert property (@(posedge clk) disable iff (sys_rst)
        decValid && decOp == decoder_pkg::LOAD_POINTER_DATA_SEG_OP |->
        clockCount == ($past(protMode) ? 21 : 7) && decIllegal == (modField == 2'h3))
        else $error("Data segment pointer load decoded wrongly.");
    chk_ptr_extra_count: assert property (@(posedge clk) disable iff (sys_rst)
        decValid && decOp == decoder_pkg::LOAD_POINTER_EXTRA_SEG_OP |->
        clockCount == ($past(protMode) ? 21 : 7))
        else $error("Extra segment pointer load count wrong.");
    chk_flag_moves: assert property (@(posedge clk) disable iff (sys_rst)
        s_flag_op_byte |=> s_flag_result)
        else $error("Flag byte transfer not finished in one byte with count 2.");
    chk_add_reg_form: assert property (@(posedge clk) disable iff (sys_rst)
        decValid && opcodeReg[7:2] == 6'h00 |->
        decOp == decoder_pkg::ADD_OP && clockCount == (memOperand ? 7 : 2))
        else $error("Add register form decoded wrongly.");
    chk_add_imm_group: assert property (@(posedge clk) disable iff (sys_rst)
        decValid && opcodeReg[7:2] == 6'h20 && regField == 3'h0 |->
        decOp == decoder_pkg::ADD_OP && immCount == (opcodeReg[1:0] == 2'h1 ? 2 : 1) &&
        clockCount == (memOperand ? 7 : 3))
        else $error("Add immediate group decoded wrongly.");
    chk_add_acc_imm: assert property (@(posedge clk) disable iff (sys_rst)
        decValid && opcodeReg[7:1] == 7'h02 |->
        decOp == decoder_pkg::ADD_OP && clockCount == 3 &&
        immCount == {opcodeReg[0], !opcodeReg[0]})
        else $error("Add accumulator immediate decoded wrongly.");
    chk_adc_forms: assert property (@(posedge clk) disable iff (sys_rst)
        decValid && (opcodeReg[7:2] == 6'h04 || opcodeReg[7:1] == 7'h0a ||
        (opcodeReg[7:2] == 6'h20 && regField == 3'h2)) |-> decOp == decoder_pkg::ADD_CARRY_OP)
        else $error("Add with carry form not recognised.");
    chk_sub_reg_form: assert property (@(posedge clk) disable iff (sys_rst)
        decValid && opcodeReg[7:2] == 6'h0a |->
        decOp == decoder_pkg::SUB_OP && clockCount == (memOperand ? 7 : 2))
        else $error("Subtract register form decoded wrongly.");
    chk_width_dir_bits: assert property (@(posedge clk) disable iff (sys_rst)
        decValid && decOp != decoder_pkg::OP_UNSUPPORTED && opcodeReg[7:6] == 2'h0 &&
        opcodeReg[2] == 1'b0 |->
        wordWidth == opcodeReg[0] && regIsDest == opcodeReg[1])
        else $error("Width or direction bit not followed.");

endmodule : load_flag_add_sub_opcode_decoder
`default_nettype wire

//--- prefetch_queue_model.sv
`timescale 1ns/1ps
`default_nettype none
module prefetch_queue_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Byte stream towards the decoder
    output logic            byteValid,
    output logic [7:0]      byteData
);
    logic [7:0] pending[$];
    int         gapCycles;
    int         idleCnt;

    // ************************************************************
    // Queue loading
    // ************************************************************
    task automatic put(input logic [7:0] b);
        pending.push_back(b);
    endtask : put

    initial begin
        byteValid = 1'b0;
        byteData  = 8'h00;
        gapCycles = 0;
        idleCnt   = 0;
    end

    // ************************************************************
    // Byte delivery
    // ************************************************************
    // Idle cycles toggle the data so a stale byte is never mistaken for a fresh one.
    always @(posedge clk) begin
        #2;
        if (!sys_rst && pending.size() > 0 && idleCnt >= gapCycles) begin
            byteValid = 1'b1;
            byteData  = pending.pop_front();
            idleCnt   = 0;
        end else begin
            byteValid = 1'b0;
            byteData  = ~byteData;
            idleCnt   = idleCnt + 1;
        end
    end
endmodule : prefetch_queue_model
`default_nettype wire

//--- load_flag_add_sub_opcode_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module load_flag_add_sub_opcode_decoder_tb;
    logic                 clk;
    logic                 sys_rst;
    logic                 protMode;
    logic                 byteValid;
    logic [7:0]           byteData;
    logic                 decValid;
    decoder_pkg::op_type  decOp;
    logic                 decUnsupported;
    logic                 decIllegal;
    logic                 wordWidth;
    logic                 regIsDest;
    logic                 memOperand;
    logic [1:0]           modField;
    logic [2:0]           regField;
    logic [2:0]           rmField;
    logic [15:0]          immValue;
    logic [1:0]           immCount;
    logic [decoder_pkg::COUNT_W-1:0] clockCount;
    int                   error_cnt;
    int                   total_checks;
    int                   cycleCnt;

    load_flag_add_sub_opcode_decoder uut (.clk(clk), .sys_rst(sys_rst), .byteValid(byteValid),
        .byteData(byteData), .protMode(protMode), .decValid(decValid), .decOp(decOp),
        .decUnsupported(decUnsupported), .decIllegal(decIllegal), .wordWidth(wordWidth),
        .regIsDest(regIsDest), .memOperand(memOperand), .modField(modField),
        .regField(regField), .rmField(rmField), .immValue(immValue), .immCount(immCount),
        .clockCount(clockCount));
    prefetch_queue_model feeder (.clk(clk), .sys_rst(sys_rst), .byteValid(byteValid),
        .byteData(byteData));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ************************************************************
    // Shared helpers
    // ************************************************************
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_dec();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            #2;
            k++;
        end while (decValid !== 1'b1 && k < 20);
        check(16'(decValid), 16'h0001);
    endtask : wait_dec

    // Bytes are packed lowest first; protMode is held over the whole instruction.
    task automatic do_instr(input int n, input logic [31:0] b, input logic pm);
        protMode = pm;
        for (int i = 0; i < n; i++) begin
            feeder.put(b[8*i +: 8]);
        end
        wait_dec();
    endtask : do_instr

    task automatic expect_dec(input decoder_pkg::op_type op, input logic [4:0] cc,
                              input logic [15:0] imm, input logic [1:0] ic,
                              input logic [2:0] mwd);
        check(16'(decOp), 16'(op));
        check(16'(clockCount), 16'(cc));
        check(immValue, imm);
        check(16'(immCount), 16'(ic));
        check(16'({memOperand, wordWidth, regIsDest}), 16'(mwd));
        check(16'(decUnsupported), 16'(op == decoder_pkg::OP_UNSUPPORTED));
    endtask : expect_dec

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic scen_load_address();
        feeder.gapCycles = 2;
        for (int pm = 0; pm < 2; pm++) begin
            do_instr(2, 32'h0000468d, pm[0]);
            expect_dec(decoder_pkg::LOAD_EFFECTIVE_ADDRESS_OP, 5'h03, 16'h0000, 2'h0, 3'h7);
            check(16'({modField, regField, rmField}), 16'h0046);
        end
        feeder.gapCycles = 0;
    endtask : scen_load_address

    task automatic scen_pointer();
        for (int i = 0; i < 4; i++) begin
            do_instr(2, {16'h0000, 8'h06, (i[1] ? 8'hc4 : 8'hc5)}, i[0]);
            expect_dec(i[1] ? decoder_pkg::LOAD_POINTER_EXTRA_SEG_OP
                : decoder_pkg::LOAD_POINTER_DATA_SEG_OP, i[0] ? 5'h15 : 5'h07,
                16'h0000, 2'h0, 3'h7);
            check(16'(decIllegal), 16'h0000);
        end
        do_instr(2, 32'h0000c0c5, 1'b0);
        check(16'(decIllegal), 16'h0001);
    endtask : scen_pointer

    task automatic scen_flags();
        feeder.put(8'h9f);
        feeder.put(8'h9e);
        wait_dec();
        expect_dec(decoder_pkg::FLAGS_TO_ACC_HIGH_OP, 5'h02, 16'h0000, 2'h0, 3'h0);
        wait_dec();
        expect_dec(decoder_pkg::ACC_HIGH_TO_FLAGS_OP, 5'h02, 16'h0000, 2'h0, 3'h0);
    endtask : scen_flags

    task automatic scen_add();
        do_instr(2, 32'h0000c100, 1'b0);
        expect_dec(decoder_pkg::ADD_OP, 5'h02, 16'h0000, 2'h0, 3'h0);
        do_instr(2, 32'h00004603, 1'b1);
        expect_dec(decoder_pkg::ADD_OP, 5'h07, 16'h0000, 2'h0, 3'h7);
        do_instr(4, 32'h1234c081, 1'b0);
        expect_dec(decoder_pkg::ADD_OP, 5'h03, 16'h1234, 2'h2, 3'h2);
        do_instr(3, 32'h00f00683, 1'b0);
        expect_dec(decoder_pkg::ADD_OP, 5'h07, 16'hfff0, 2'h1, 3'h6);
        do_instr(3, 32'h007fc380, 1'b0);
        expect_dec(decoder_pkg::ADD_OP, 5'h03, 16'h007f, 2'h1, 3'h0);
        do_instr(3, 32'h00abcd05, 1'b0);
        expect_dec(decoder_pkg::ADD_OP, 5'h03, 16'habcd, 2'h2, 3'h2);
        do_instr(2, 32'h00008004, 1'b1);
        expect_dec(decoder_pkg::ADD_OP, 5'h03, 16'h0080, 2'h1, 3'h0);
    endtask : scen_add

    task automatic scen_carry_sub();
        do_instr(2, 32'h0000c812, 1'b0);
        expect_dec(decoder_pkg::ADD_CARRY_OP, 5'h02, 16'h0000, 2'h0, 3'h1);
        do_instr(3, 32'h0005d183, 1'b1);
        expect_dec(decoder_pkg::ADD_CARRY_OP, 5'h03, 16'h0005, 2'h1, 3'h2);
        do_instr(3, 32'h00123415, 1'b0);
        expect_dec(decoder_pkg::ADD_CARRY_OP, 5'h03, 16'h1234, 2'h2, 3'h2);
        do_instr(2, 32'h0000d829, 1'b0);
        expect_dec(decoder_pkg::SUB_OP, 5'h02, 16'h0000, 2'h0, 3'h2);
        do_instr(2, 32'h0000072a, 1'b1);
        expect_dec(decoder_pkg::SUB_OP, 5'h07, 16'h0000, 2'h0, 3'h5);
    endtask : scen_carry_sub

    task automatic scen_outside();
        do_instr(1, 32'h0000009c, 1'b0);
        check(16'(decOp), 16'(decoder_pkg::OP_UNSUPPORTED));
        do_instr(4, 32'h1234f881, 1'b0);
        check(16'(decUnsupported), 16'h0001);
        do_instr(1, 32'h0000009f, 1'b0);
        expect_dec(decoder_pkg::FLAGS_TO_ACC_HIGH_OP, 5'h02, 16'h0000, 2'h0, 3'h0);
    endtask : scen_outside

    always @(posedge clk) begin
        cycleCnt++;
        if (cycleCnt > 3000) begin
            error_cnt++;
            stop_test();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        error_cnt    = 0;
        total_checks = 0;
        cycleCnt     = 0;
        sys_rst      = 1'b1;
        protMode     = 1'b0;
        repeat (4) @(posedge clk);
        #2;
        check(16'(decValid), 16'h0000);
        check(16'(decOp), 16'(decoder_pkg::OP_UNSUPPORTED));
        sys_rst = 1'b0;
        scen_load_address();
        scen_pointer();
        scen_flags();
        scen_add();
        scen_carry_sub();
        scen_outside();
        stop_test();
    end
endmodule : load_flag_add_sub_opcode_decoder_tb
`default_nettype wire
